/* File: rtl/fsc_pkg.sv */
// Constants shared by the flash status-two and config-one register bank
package fsc_pkg;

    // ==========================================================
    // Serial command codes
    localparam logic [7:0]  CMD_READ_SECOND_STATUS = 8'h07;
    localparam logic [7:0]  CMD_READ_ANY_REGISTER  = 8'h65;
    localparam logic [7:0]  CMD_WRITE_REGISTERS    = 8'h01;
    localparam logic [7:0]  CMD_WRITE_ANY_REGISTER = 8'h71;

    // ==========================================================
    // Register addresses used by the any-register commands
    localparam logic [23:0] ADDR_ERASE_SUSPEND_STATUS = 24'h800001;
    localparam logic [23:0] ADDR_NONVOLATILE_CONFIG   = 24'h000002;

    // ==========================================================
    // Field positions
    localparam int unsigned ESS_ERASE_DONE   = 2;
    localparam int unsigned ESS_ERASE_SUSP   = 1;
    localparam int unsigned ESS_PROG_SUSP    = 0;
    localparam int unsigned CFG_PROT_ORIGIN  = 5;
    localparam int unsigned CFG_SOURCE_SEL   = 3;
    localparam int unsigned CFG_PARAM_LOC    = 2;
    localparam int unsigned CFG_QUAD_DEFAULT = 1;
    localparam int unsigned CFG_FREEZE_DEF   = 0;
    localparam int unsigned STAT_BP_LSB      = 2;

    // ==========================================================
    // Masks and values after reset
    localparam logic [7:0]  CFG_OTP_MASK  = 8'h2C;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  ESS_RESET     = 8'h00;
    localparam logic [2:0]  BP_RESET      = 3'h0;
    localparam logic [2:0]  BP_ALL_SET    = 3'h7;

    // ==========================================================
    // Byte positions inside a frame (byte 0 is the command)
    localparam logic [2:0]  BYTE_ADDR_HI   = 3'h1;
    localparam logic [2:0]  BYTE_ADDR_MID  = 3'h2;
    localparam logic [2:0]  BYTE_ADDR_LO   = 3'h3;
    localparam logic [2:0]  BYTE_ANY_DATA  = 3'h4;
    localparam logic [2:0]  BYTE_LAST      = 3'h5;
    localparam logic [2:0]  NB_WRR_STATUS  = 3'h2;
    localparam logic [2:0]  NB_WRR_CONFIG  = 3'h3;
    localparam logic [2:0]  NB_WRITE_ANY   = 3'h5;

    // ==========================================================
    // Write times and their cycle counts at the system clock
    localparam int unsigned SYS_CLK_MHZ   = 20;
    localparam int unsigned NV_WRITE_NS   = 500000;
    localparam int unsigned VOL_WRITE_NS  = 50;
    localparam int unsigned NV_WRITE_CYC  = (NV_WRITE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int unsigned VOL_WRITE_CYC = (VOL_WRITE_NS * SYS_CLK_MHZ + 999) / 1000;

endpackage

/* File: rtl/fsc_regs.sv */
// Status-two and config-one register bank behind the serial command port
`timescale 1ns/1ns

module fsc_regs #(
    parameter int unsigned NV_WRITE_CYC = fsc_pkg::NV_WRITE_CYC   // Non-volatile write cycles
) (
    input  wire logic       sys_clk,            // System clock, 20 MHz
    input  wire logic       rstn,               // Power-on / hardware reset, low
    input  wire logic       spi_sck,            // Serial clock from host
    input  wire logic       spi_cs_n,           // Chip select, low
    input  wire logic       spi_si,             // Serial data in
    output logic            spi_so_o,           // Serial data out
    output logic            spi_so_oe,          // Serial out drive enable
    input  wire logic       erase_status_load,  // Erase status check done pulse
    input  wire logic       erase_status_value, // Its result, 1 = completed
    input  wire logic       erase_suspended,    // Core in erase suspend
    input  wire logic       program_suspended,  // Core in program suspend
    input  wire logic       write_enabled,      // Write enable latch state
    input  wire logic       qpi_volatile,       // Volatile four-wire protocol on
    input  wire logic       qpi_nv_program,     // Four-wire enable programmed pulse
    input  wire logic       uniform_sectors,    // Array uses uniform sectors
    input  wire logic       cmd_reset,          // Command reset pulse
    output logic            protection_origin,  // 1 = protect from bottom
    output logic            protect_source,     // 1 = volatile protect bits rule
    output logic            parameter_location, // 1 = parameter sectors at top
    output logic            quad_width,         // Volatile quad width
    output logic            freeze,             // Volatile freeze
    output logic [2:0]      block_protect,      // Volatile protect bits
    output logic [2:0]      nv_block_protect,   // Non-volatile protect bits
    output logic            write_busy          // Register write in progress
);

    localparam int unsigned BUSY_W = $clog2(NV_WRITE_CYC + 1);

    // ==========================================================
    // Config merge shared by both write commands
    function automatic logic [7:0] fsc_cfg_merge(
        input logic [7:0] old_v,
        input logic [7:0] wr_v,
        input logic       qpi_on,
        input logic       frozen
    );
        logic [7:0] res;
        logic       quad;
        res = 8'h00;
        // One-time bits only ever gain ones; freeze holds them
        res = frozen ? (old_v & fsc_pkg::CFG_OTP_MASK)
                     : ((old_v | wr_v) & fsc_pkg::CFG_OTP_MASK);
        quad = qpi_on ? (old_v[fsc_pkg::CFG_QUAD_DEFAULT] | wr_v[fsc_pkg::CFG_QUAD_DEFAULT])
                      : wr_v[fsc_pkg::CFG_QUAD_DEFAULT];
        res[fsc_pkg::CFG_QUAD_DEFAULT] = quad;
        res[fsc_pkg::CFG_FREEZE_DEF] = old_v[fsc_pkg::CFG_FREEZE_DEF];
        return res;
    endfunction

    // ==========================================================
    // Link side: frame position, cleared while chip select is high
    logic [2:0]  bit_q;
    logic [2:0]  byte_q;
    logic [6:0]  shift_q;
    logic [7:0]  cmd_q;
    logic [23:0] addr_q;
    logic [7:0]  data0_q;
    logic [7:0]  data1_q;
    logic [7:0]  any_data_q;
    logic [2:0]  nbytes_q;
    logic [7:0]  byte_in;
    logic        byte_end;

    assign byte_in  = {shift_q, spi_si};
    assign byte_end = (bit_q == 3'h7);

    // Frame counters; the clock stops between frames so the select clears them
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_q  <= 3'h0;
            byte_q <= 3'h0;
        end else begin
            bit_q <= bit_q + 3'h1;
            if (byte_end && byte_q != fsc_pkg::BYTE_LAST) begin
                byte_q <= byte_q + 3'h1;
            end
        end
    end

    // Captured bytes survive the frame end so the system side can read them
    always_ff @(posedge spi_sck) begin
        shift_q <= byte_in[6:0];
        if (bit_q == 3'h0 && byte_q == 3'h0) begin
            nbytes_q <= 3'h0;
        end else if (byte_end) begin
            nbytes_q <= byte_q + 3'h1;
        end
        if (byte_end) begin
            unique case (byte_q)
                3'h0: begin
                    cmd_q <= byte_in;
                end
                fsc_pkg::BYTE_ADDR_HI: begin
                    addr_q[23:16] <= byte_in;
                    data0_q       <= byte_in;
                end
                fsc_pkg::BYTE_ADDR_MID: begin
                    addr_q[15:8] <= byte_in;
                    data1_q      <= byte_in;
                end
                fsc_pkg::BYTE_ADDR_LO: begin
                    addr_q[7:0] <= byte_in;
                end
                fsc_pkg::BYTE_ANY_DATA: begin
                    any_data_q <= byte_in;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Register values carried into the link domain
    logic [7:0] ess_q;
    logic [7:0] cfg_q;
    logic [7:0] ess_l1_q;
    logic [7:0] ess_l2_q;
    logic [7:0] cfg_l1_q;
    logic [7:0] cfg_l2_q;
    logic [7:0] rd_byte;
    logic       rd_phase;

    // Bits are independent levels that change rarely; eight edges precede any read
    always_ff @(posedge spi_sck) begin
        ess_l1_q <= ess_q;
        ess_l2_q <= ess_l1_q;
        cfg_l1_q <= cfg_q;
        cfg_l2_q <= cfg_l1_q;
    end

    // Read data select; unknown addresses read zero
    always_comb begin
        rd_byte = 8'h00;
        if (cmd_q == fsc_pkg::CMD_READ_SECOND_STATUS) begin
            rd_byte = ess_l2_q;
        end else if (cmd_q == fsc_pkg::CMD_READ_ANY_REGISTER) begin
            if (addr_q == fsc_pkg::ADDR_ERASE_SUSPEND_STATUS) begin
                rd_byte = ess_l2_q;
            end else if (addr_q == fsc_pkg::ADDR_NONVOLATILE_CONFIG) begin
                rd_byte = cfg_l2_q;
            end
        end
    end

    assign rd_phase = (cmd_q == fsc_pkg::CMD_READ_SECOND_STATUS && byte_q >= 3'h1) ||
                      (cmd_q == fsc_pkg::CMD_READ_ANY_REGISTER &&
                       byte_q >= fsc_pkg::BYTE_ANY_DATA);

    // Output shifts on the falling edge, most significant bit first
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_so_o  <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            spi_so_o  <= rd_byte[3'h7 - bit_q];
            spi_so_oe <= rd_phase;
        end
    end

    // ==========================================================
    // System side: frame end seen through a synchroniser
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic frame_end;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= spi_cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // Captured bytes are stable once the select has risen and the clock stopped
    assign frame_end = cs_s2_q && !cs_s3_q;

    // ==========================================================
    // Command decode at frame end
    logic [BUSY_W-1:0] busy_cnt_q;
    logic              wrr_go;
    logic              wrr_cfg;
    logic              war_go;
    logic              cfg_go;
    logic [7:0]        cfg_wr;
    logic [7:0]        cfg_new;
    logic              nonvolatile_block_protect_bits_wr;
    logic              bp_vol_wr;
    logic [2:0]        bp_wr;
    logic [2:0]        nv_bp_q;
    logic [2:0]        vol_bp_q;
    logic              quad_q;
    logic              freeze_q;

    // Writes need the enable latch and are ignored while a write is timing
    assign wrr_go  = frame_end && write_enabled && busy_cnt_q == '0 &&
                     cmd_q == fsc_pkg::CMD_WRITE_REGISTERS &&
                     nbytes_q >= fsc_pkg::NB_WRR_STATUS;
    assign wrr_cfg = wrr_go && nbytes_q >= fsc_pkg::NB_WRR_CONFIG;
    assign war_go  = frame_end && write_enabled && busy_cnt_q == '0 &&
                     cmd_q == fsc_pkg::CMD_WRITE_ANY_REGISTER &&
                     nbytes_q >= fsc_pkg::NB_WRITE_ANY &&
                     addr_q == fsc_pkg::ADDR_NONVOLATILE_CONFIG;
    assign cfg_go  = wrr_cfg || war_go;
    assign cfg_wr  = war_go ? any_data_q : data1_q;
    assign cfg_new = fsc_cfg_merge(cfg_q, cfg_wr, qpi_volatile, freeze_q);
    assign bp_wr   = data0_q[fsc_pkg::STAT_BP_LSB +: 3];
    // Protect bits go to both copies, or only to the volatile copy when the source select is set
    assign nonvolatile_block_protect_bits_wr  = wrr_go && !freeze_q && !cfg_q[fsc_pkg::CFG_SOURCE_SEL];
    assign bp_vol_wr = wrr_go && !freeze_q && cfg_q[fsc_pkg::CFG_SOURCE_SEL];

    // ==========================================================
    // Non-volatile config; storage modelled as flops cleared by reset
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfg_q <= fsc_pkg::CFG_RESET;
        end else if (cfg_go) begin
            cfg_q <= cfg_new;
            if (qpi_nv_program) begin
                cfg_q[fsc_pkg::CFG_QUAD_DEFAULT] <= 1'b1;
            end
        end else if (qpi_nv_program) begin
            cfg_q[fsc_pkg::CFG_QUAD_DEFAULT] <= 1'b1;
        end
    end

    // Non-volatile protect bits
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            nv_bp_q <= fsc_pkg::BP_RESET;
        end else if (cfg_go && cfg_new[fsc_pkg::CFG_SOURCE_SEL] &&
                     !cfg_q[fsc_pkg::CFG_SOURCE_SEL]) begin
            nv_bp_q <= fsc_pkg::BP_ALL_SET;
        end else if (nonvolatile_block_protect_bits_wr) begin
            nv_bp_q <= bp_wr;
        end
    end

    // Volatile protect bits reload from the stored copy on command reset; hardware reset clears them
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            vol_bp_q <= fsc_pkg::BP_RESET;
        end else if (cmd_reset) begin
            vol_bp_q <= nv_bp_q;
        end else if (nonvolatile_block_protect_bits_wr || bp_vol_wr) begin
            vol_bp_q <= bp_wr;
        end
    end

    // Volatile quad and freeze; command reset leaves freeze alone
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            quad_q   <= fsc_pkg::CFG_RESET[fsc_pkg::CFG_QUAD_DEFAULT];
            freeze_q <= fsc_pkg::CFG_RESET[fsc_pkg::CFG_FREEZE_DEF];
        end else begin
            if (cmd_reset) begin
                quad_q <= cfg_q[fsc_pkg::CFG_QUAD_DEFAULT];
            end else if (cfg_go) begin
                quad_q <= cfg_new[fsc_pkg::CFG_QUAD_DEFAULT];
            end
            if (wrr_cfg && cfg_wr[fsc_pkg::CFG_FREEZE_DEF]) begin
                freeze_q <= 1'b1;
            end
        end
    end

    // Write timer: non-volatile time if any stored bit is written
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            busy_cnt_q <= '0;
        end else if (cfg_go || nonvolatile_block_protect_bits_wr) begin
            busy_cnt_q <= BUSY_W'(NV_WRITE_CYC);
        end else if (bp_vol_wr) begin
            busy_cnt_q <= BUSY_W'(fsc_pkg::VOL_WRITE_CYC);
        end else if (busy_cnt_q != '0) begin
            busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
        end
    end

    // ==========================================================
    // Erase and suspend status; only hardware sets these bits
    logic erase_completion_bit_q;

    // Result held until the next status check
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            erase_completion_bit_q <= 1'b0;
        end else if (erase_status_load) begin
            erase_completion_bit_q <= erase_status_value;
        end
    end

    // Suspend bits pass straight through; erase-done is left raw during suspend
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ess_q <= fsc_pkg::ESS_RESET;
        end else begin
            ess_q <= 8'h00;
            ess_q[fsc_pkg::ESS_ERASE_DONE] <= erase_completion_bit_q;
            ess_q[fsc_pkg::ESS_ERASE_SUSP] <= erase_suspended;
            ess_q[fsc_pkg::ESS_PROG_SUSP]  <= program_suspended;
        end
    end

    // ==========================================================
    // Outputs
    assign protection_origin  = cfg_q[fsc_pkg::CFG_PROT_ORIGIN];
    assign protect_source     = cfg_q[fsc_pkg::CFG_SOURCE_SEL];
    assign parameter_location = cfg_q[fsc_pkg::CFG_PARAM_LOC] && !uniform_sectors;
    assign quad_width         = quad_q;
    assign freeze             = freeze_q;
    assign block_protect      = vol_bp_q;
    assign nv_block_protect   = nv_bp_q;
    assign write_busy         = busy_cnt_q != '0;

    // ==========================================================
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence nv_write_s;
        nonvolatile_block_protect_bits_wr;
    endsequence

    sequence vol_write_s;
        bp_vol_wr && !cfg_go;
    endsequence

    sequence short_busy_s;
        write_busy ##1 !write_busy;
    endsequence

    erase_done_a: assert property (erase_status_load ##2 !erase_status_load
                                   |-> ess_q[2] == $past(erase_status_value, 2))
        else $error("erase done bit does not hold check result");
    erase_susp_a: assert property (ess_q[1] == $past(erase_suspended) &&
                                   ess_q[7:3] == 5'h00)
        else $error("erase suspend bit wrong");
    prog_susp_a: assert property (ess_q[0] == $past(program_suspended))
        else $error("program suspend bit wrong");
    otp_sticky_a: assert property ((cfg_q & fsc_pkg::CFG_OTP_MASK) != 8'h00
                                   |=> (cfg_q & $past(cfg_q) & fsc_pkg::CFG_OTP_MASK)
                                       == ($past(cfg_q) & fsc_pkg::CFG_OTP_MASK))
        else $error("one-time bit cleared");
    src_bp_a: assert property ($rose(cfg_q[3]) |-> nv_bp_q == 3'h7)
        else $error("source select set without stored protect all ones");
    nv_time_a: assert property (nv_write_s |=> write_busy [*8])
        else $error("non-volatile write too short");
    vol_time_a: assert property (vol_write_s |=> short_busy_s and $stable(nv_bp_q))
        else $error("volatile protect write timing or stored copy wrong");
    quad_hold_a: assert property (qpi_volatile && cfg_q[1] |=> cfg_q[1])
        else $error("quad default cleared under four-wire protocol");
    freeze_def_a: assert property (cfg_q[0] == 1'b0 && cfg_q[7:6] == 2'h0)
        else $error("freeze default or reserved bit set");
    param_loc_a: assert property (uniform_sectors |-> !parameter_location)
        else $error("parameter location active with uniform sectors");

endmodule

/* File: verif/fsc_host.sv */
// Serial host model driving register command frames into the bank
`timescale 1ns/1ns

module fsc_host (
    output logic      spi_sck,   // Serial clock, idle low
    output logic      spi_cs_n,  // Chip select, low active
    output logic      spi_si,    // Data to device
    input  wire logic spi_so_o,  // Data from device
    input  wire logic spi_so_oe  // Device drives so
);
    // ==========================================================
    // Idle lines before the first frame
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end

    // ==========================================================
    // One whole frame, MSB first, 32 ns clock that stops between frames
    task automatic xfer(input logic [47:0] tx, input int nb, output logic [7:0] rx);
        spi_cs_n = 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            spi_si = tx[47 - i];
            #16 spi_sck = 1'b1;
            rx = {rx[6:0], spi_so_oe ? spi_so_o : 1'bx}; // Undriven so never passes
            #16 spi_sck = 1'b0;
        end
        // Released data line must not keep the last level
        spi_si = ~spi_si;
        #16 spi_cs_n = 1'b1;
    endtask
endmodule

/* File: verif/tb_flash_status2_config1_regs.sv */
// Self-checking bench for the status-two and config-one register bank
`timescale 1ns/1ns

module tb_flash_status2_config1_regs;
    localparam int NVC = 16;
    logic       sys_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       erase_status_load, erase_status_value, erase_suspended, program_suspended;
    logic       write_enabled, qpi_volatile, qpi_nv_program, uniform_sectors, cmd_reset;
    wire        spi_sck, spi_cs_n, spi_si, spi_so_o, spi_so_oe, write_busy;
    wire        protection_origin, protect_source, parameter_location, quad_width, freeze;
    wire  [2:0] block_protect, nv_block_protect;
    int         err_count = 0;
    int         compares = 0;
    int         seed = 32'h8cef;
    int         n;
    logic [7:0] rd, w, cfg;
    logic [2:0] bp;

    fsc_regs #(.NV_WRITE_CYC(NVC)) DUT (.sys_clk, .rstn, .spi_sck, .spi_cs_n, .spi_si,
        .spi_so_o, .spi_so_oe, .erase_status_load, .erase_status_value, .erase_suspended,
        .program_suspended, .write_enabled, .qpi_volatile, .qpi_nv_program, .uniform_sectors,
        .cmd_reset, .protection_origin, .protect_source, .parameter_location, .quad_width,
        .freeze, .block_protect, .nv_block_protect, .write_busy);
    fsc_host host (.spi_sck, .spi_cs_n, .spi_si, .spi_so_o, .spi_so_oe);

    always #25 sys_clk = ~sys_clk;

    // ==========================================================
    // Checking and frame helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Frame, then 40 cycles of gap counting busy cycles (covers the cs-high spacing)
    task automatic go(input logic [47:0] tx, input int nb);
        host.xfer(tx, nb, rd);
        n = 0;
        repeat (40) begin
            @(posedge sys_clk);
            if (write_busy === 1'b1) n++;
        end
    endtask

    task automatic rdany(input logic [23:0] a);
        go({fsc_pkg::CMD_READ_ANY_REGISTER, a, 16'h0000}, 5);
    endtask

    task automatic wrany(input logic [23:0] a, input logic [7:0] d);
        go({fsc_pkg::CMD_WRITE_ANY_REGISTER, a, d, 8'h00}, 5);
    endtask

    // Expected stored config: one-time bits only set, quad clear refused under four-wire
    function automatic logic [7:0] nxt(input logic [7:0] o, input logic [7:0] v, input logic q);
        nxt = (o | v) & fsc_pkg::CFG_OTP_MASK;
        nxt[1] = v[1] | (q & o[1]);
    endfunction

    task automatic tally_and_finish;
        $display("compares %0d, err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the roughly 120 us the sequence needs
    initial begin
        #2000000;
        err_count++;
        tally_and_finish;
    end

    // ==========================================================
    // Main sequence
    initial begin
        {erase_status_load, erase_status_value, erase_suspended, program_suspended} = 4'h0;
        {write_enabled, qpi_volatile, qpi_nv_program, uniform_sectors, cmd_reset} = 5'h00;
        cfg = 8'h00;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        write_enabled <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({protection_origin, protect_source, parameter_location, quad_width, freeze,
             block_protect, nv_block_protect}, 0, "reset");
        // Status follows the core; user writes to it do nothing
        for (int k = 0; k < 6; k++) begin
            {erase_status_value, erase_suspended, program_suspended} <= 3'($random(seed));
            erase_status_load <= 1'b1;
            @(posedge sys_clk);
            erase_status_load <= 1'b0;
            repeat (4) @(posedge sys_clk);
            go({fsc_pkg::CMD_READ_SECOND_STATUS, 40'h0}, 2);
            chk(rd, {erase_status_value, erase_suspended, program_suspended}, "rd2");
            wrany(fsc_pkg::ADDR_ERASE_SUSPEND_STATUS, 8'hFF);
            rdany(fsc_pkg::ADDR_ERASE_SUSPEND_STATUS);
            chk(rd, {erase_status_value, erase_suspended, program_suspended}, "rdany");
        end
        // Stored protect bits under non-volatile source
        bp = 3'($random(seed));
        go({fsc_pkg::CMD_WRITE_REGISTERS, 3'h0, bp, 2'h0, 32'h0}, 2);
        chk({nv_block_protect, block_protect}, {bp, bp}, "nonvolatile_block_protect_bits");
        chk(n, NVC, "nv time");
        // Random config writes, first one a hand-picked origin-only corner
        for (int k = 0; k < 5; k++) begin
            {uniform_sectors, qpi_volatile} <= 2'($random(seed));
            w = (k == 0) ? 8'h20 : 8'($random(seed)) & 8'hFE;
            wrany(fsc_pkg::ADDR_NONVOLATILE_CONFIG, w);
            cfg = nxt(cfg, w, qpi_volatile);
            chk(n, NVC, "cfg time");
            rdany(fsc_pkg::ADDR_NONVOLATILE_CONFIG);
            chk(rd, cfg, "cfg");
            chk({protection_origin, protect_source, parameter_location},
                {cfg[5], cfg[3], cfg[2] & ~uniform_sectors}, "cfg pins");
        end
        // Select volatile source through a sixteen-bit write-registers frame
        w = cfg | 8'h08;
        go({fsc_pkg::CMD_WRITE_REGISTERS, 8'h00, w, 24'h0}, 3);
        cfg = nxt(cfg, w, qpi_volatile);
        chk(nv_block_protect, 3'h7, "src set");
        bp = 3'($random(seed));
        go({fsc_pkg::CMD_WRITE_REGISTERS, 3'h0, bp, 2'h0, 32'h0}, 2);
        chk({nv_block_protect, block_protect}, {3'h7, bp}, "bp vol");
        chk(n, 1, "vol time");
        cmd_reset <= 1'b1;
        @(posedge sys_clk);
        cmd_reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({block_protect, quad_width}, {3'h7, cfg[1]}, "cmd reset");
        // Four-wire enable programmed sets the quad default
        qpi_volatile <= 1'b0;
        qpi_nv_program <= 1'b1;
        @(posedge sys_clk);
        qpi_nv_program <= 1'b0;
        cfg[1] = 1'b1;
        rdany(fsc_pkg::ADDR_NONVOLATILE_CONFIG);
        chk(rd, cfg, "quad_width_default");
        // Clearing everything: one-time bits hold, quad clear refused
        qpi_volatile <= 1'b1;
        wrany(fsc_pkg::ADDR_NONVOLATILE_CONFIG, 8'h00);
        rdany(fsc_pkg::ADDR_NONVOLATILE_CONFIG);
        chk(rd, cfg, "quad hold");
        // Freeze default stays zero even when bit 0 is written
        go({fsc_pkg::CMD_WRITE_REGISTERS, 8'h00, cfg | 8'h01, 24'h0}, 3);
        rdany(fsc_pkg::ADDR_NONVOLATILE_CONFIG);
        chk(rd, cfg, "freeze def");
        chk(freeze, 1'b1, "freeze set");
        // Frozen protect bits ignore a write-registers frame
        go({fsc_pkg::CMD_WRITE_REGISTERS, 8'h1C, 32'h0}, 2);
        chk(block_protect, 3'h0, "frozen bp");
        // Write latch off: config write refused, no write time spent
        write_enabled <= 1'b0;
        wrany(fsc_pkg::ADDR_NONVOLATILE_CONFIG, 8'h26);
        chk(n, 0, "latch off time");
        rdany(fsc_pkg::ADDR_NONVOLATILE_CONFIG);
        chk(rd, cfg, "latch off cfg");
        tally_and_finish;
    end
endmodule
